// [ipd_pkg.sv]
// ipd_pkg: constants of the in-position detector (register map, fields, limits, timing).
// assumes a 50 MHz core clock and 32-bit apb data.
// Function
// R01: mode 0: primary on when deviation below range
// R02: mode 1: also requires no position command
// R03: mode 2: also requires zero-speed active
// R04: mode 3: primary held on after turning on
// R05: mode 3: after hold, follow live conditions
// R06: mode 3: zero hold holds until next command
// R07: mode 3: hold ms count, command clears at once
// R08: mode 4: evaluate only after delay from command end
// R09: mode 4: on when no command, deviation not above
// R10: mode 4: zero delay evaluates immediately
// R11: mode 4: command during delay resets counter
// R12: mode 4: delay measured from zero again
// R13: secondary on when deviation below range two
// R14: secondary ignores position command presence
// R15: command presence taken after command filter
// R16: accept modes 0-4, times 0-30000 ms only
// R17: compare absolute deviation against thresholds
// R18: primary range programmable 0 to 262144 pulses
// R19: one millisecond tick from the system clock
package ipd_pkg;
    localparam int DEV_W = 28;
    localparam int RANGE_W = 19;
    localparam int MODE_W = 3;
    localparam int TIME_W = 15;
    localparam int PADDR_W = 8;
    localparam int EVT_W = 4;

    localparam logic [PADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [PADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [PADDR_W-1:0] OFS_RANGE1 = 8'h08;
    localparam logic [PADDR_W-1:0] OFS_RANGE2 = 8'h0C;
    localparam logic [PADDR_W-1:0] OFS_HOLD = 8'h10;
    localparam logic [PADDR_W-1:0] OFS_INT_STAT = 8'h14;
    localparam logic [PADDR_W-1:0] OFS_INT_MASK = 8'h18;

    // event bit positions in int_stat / int_mask
    localparam int EVT_PRIM_ON = 0;
    localparam int EVT_PRIM_OFF = 1;
    localparam int EVT_SEC_ON = 2;
    localparam int EVT_SEC_OFF = 3;

    // status register bit positions
    localparam int ST_PRIM = 0;
    localparam int ST_SEC = 1;
    localparam int ST_BELOW1 = 2;
    localparam int ST_CMD = 3;
    localparam int ST_STATE_LSB = 4;

    localparam logic [MODE_W-1:0] MODE_MAX = 3'h4;
    localparam logic [TIME_W-1:0] TIME_MAX = 15'h7530;
    localparam logic [RANGE_W-1:0] RANGE_MAX = 19'h40000;

    localparam logic [MODE_W-1:0] RST_MODE = 3'h0;
    localparam logic [TIME_W-1:0] RST_HOLD = 15'h0000;
    localparam logic [RANGE_W-1:0] RST_RANGE1 = 19'h0000A;
    localparam logic [RANGE_W-1:0] RST_RANGE2 = 19'h0000A;
    localparam logic [EVT_W-1:0] RST_MASK = 4'h0;

    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 16;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HOLDING,
        ST_DELAYING,
        ST_EVALUATING
    } ipd_state_t;
endpackage : ipd_pkg

// [ipd_ms_tick.sv]
// ipd_ms_tick: millisecond tick prescaler for the hold and delay timers.
// assumes a free running core clock; restart realigns the first tick.
module ipd_ms_tick #(
    parameter int unsigned TICK_CYCLES = ipd_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic restart,
    output logic tick
);
    logic [ipd_pkg::TICK_W-1:0] pre_r;
    localparam logic [ipd_pkg::TICK_W-1:0] LAST = ipd_pkg::TICK_W'(TICK_CYCLES - 1);

    // restart keeps the first millisecond whole after a timer start
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_r <= '0;
            tick <= 1'b0;
        end else if (ce) begin
            if (restart) begin
                pre_r <= '0;
                tick <= 1'b0;
            end else if (pre_r == LAST) begin
                pre_r <= '0;
                tick <= 1'b1; // [R19]
            end else begin
                pre_r <= pre_r + 1'b1;
                tick <= 1'b0;
            end
        end
    end
endmodule : ipd_ms_tick

// [ipd_in_position_detector.sv]
// ipd_in_position_detector: in-position flags with apb registers and interrupt.
// assumes deviation, command and zero-speed inputs are synchronous to core_clk.
//
// Local design decisions: the APB slave port and the address map.
module ipd_in_position_detector #(
    parameter int unsigned TICK_CYCLES = ipd_pkg::TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic signed [ipd_pkg::DEV_W-1:0] pos_deviation,
    input wire logic cmd_present_filt,
    input wire logic zero_speed,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ipd_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic inpos_flag_primary,
    output logic inpos_flag_secondary,
    output logic irq
);
    localparam int DW = ipd_pkg::DEV_W;
    localparam int RW = ipd_pkg::RANGE_W;
    localparam int TW = ipd_pkg::TIME_W;
    localparam int EW = ipd_pkg::EVT_W;

    logic [ipd_pkg::MODE_W-1:0] inpos_condition_select_r;
    logic [RW-1:0] inpos_range_primary_r;
    logic [RW-1:0] inpos_range_secondary_r;
    logic [TW-1:0] inpos_hold_delay_time_r;
    logic [EW-1:0] int_stat_r;
    logic [EW-1:0] int_mask_r;
    logic [EW-1:0] evt;
    logic [TW-1:0] cnt_r;
    logic cmd_d_r;
    logic prim_nxt;
    logic sec_nxt;
    logic ms_tick;
    logic timer_start;
    logic ctrl_wr;
    logic [DW-1:0] dev_mag;
    logic [DW-1:0] range1_ext;
    logic [DW-1:0] range2_ext;
    logic below1;
    logic within1;
    logic below2;
    logic hold_cond;
    logic cmd_fall;
    logic [TW-1:0] cnt_nxt;
    logic [TW-1:0] cnt_inc;
    ipd_pkg::ipd_state_t state_r;
    ipd_pkg::ipd_state_t state_nxt;
    logic apb_access;
    logic apb_commit;
    logic wr_commit;
    logic addr_ok;
    logic value_ok;
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    logic [EW-1:0] stat_clr;

    // ms base for hold and delay; restarted so a timer's first ms is whole
    ipd_ms_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) tick_u (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .restart(timer_start),
        .tick(ms_tick)
    );

    // two's complement magnitude; the most negative value still fits unsigned
    always_comb begin
        if (pos_deviation[DW-1]) begin
            dev_mag = $unsigned(-pos_deviation); // [R17]
        end else begin
            dev_mag = $unsigned(pos_deviation); // [R17]
        end
    end

    assign range1_ext = {{(DW-RW){1'b0}}, inpos_range_primary_r};
    assign range2_ext = {{(DW-RW){1'b0}}, inpos_range_secondary_r};
    assign below1 = dev_mag < range1_ext; // [R01]
    assign within1 = dev_mag <= range1_ext; // [R09]
    assign below2 = dev_mag < range2_ext; // [R13]

    // the loop hands over the filtered command stream, never the raw one
    assign hold_cond = !cmd_present_filt && below1; // [R15]
    assign cmd_fall = cmd_d_r && !cmd_present_filt; // [R08]
    assign cnt_inc = cnt_r + 1'b1;

    // secondary flag ignores condition setting and command presence
    assign sec_nxt = below2; // [R14]

    // previous command level, for the end-of-command edge
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_d_r <= 1'b0;
        end else if (ce) begin
            cmd_d_r <= cmd_present_filt;
        end
    end

    // flag qualification for each condition setting
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        timer_start = 1'b0;
        prim_nxt = 1'b0;
        case (inpos_condition_select_r)
            3'h0: begin
                state_nxt = ipd_pkg::ST_IDLE;
                prim_nxt = below1; // [R01]
            end
            3'h1: begin
                state_nxt = ipd_pkg::ST_IDLE;
                prim_nxt = hold_cond; // [R02]
            end
            3'h2: begin
                state_nxt = ipd_pkg::ST_IDLE;
                prim_nxt = hold_cond && zero_speed; // [R03]
            end
            3'h3: begin
                case (state_r)
                    ipd_pkg::ST_IDLE: begin
                        if (hold_cond) begin
                            prim_nxt = 1'b1; // [R04]
                            state_nxt = ipd_pkg::ST_HOLDING;
                            cnt_nxt = '0;
                            timer_start = 1'b1;
                        end
                    end
                    ipd_pkg::ST_HOLDING: begin
                        if (cmd_present_filt) begin
                            // a new command cuts any hold short
                            state_nxt = ipd_pkg::ST_IDLE; // [R07]
                        end else if (inpos_hold_delay_time_r == '0) begin
                            prim_nxt = 1'b1; // [R06]
                        end else if (ms_tick && cnt_inc >= inpos_hold_delay_time_r) begin
                            state_nxt = ipd_pkg::ST_EVALUATING;
                            prim_nxt = hold_cond; // [R05]
                        end else begin
                            prim_nxt = 1'b1; // [R04]
                            if (ms_tick) begin
                                cnt_nxt = cnt_inc; // [R07]
                            end
                        end
                    end
                    ipd_pkg::ST_EVALUATING: begin
                        // after the hold the flag follows the live conditions
                        prim_nxt = hold_cond; // [R05]
                        if (!hold_cond) begin
                            state_nxt = ipd_pkg::ST_IDLE;
                        end
                    end
                    default: begin
                        state_nxt = ipd_pkg::ST_IDLE;
                    end
                endcase
            end
            3'h4: begin
                case (state_r)
                    ipd_pkg::ST_IDLE: begin
                        if (cmd_fall) begin
                            if (inpos_hold_delay_time_r == '0) begin
                                state_nxt = ipd_pkg::ST_EVALUATING; // [R10]
                                prim_nxt = within1; // [R10]
                            end else begin
                                state_nxt = ipd_pkg::ST_DELAYING;
                                cnt_nxt = '0; // [R12]
                                timer_start = 1'b1;
                            end
                        end
                    end
                    ipd_pkg::ST_DELAYING: begin
                        if (cmd_present_filt) begin
                            // the next end of command measures from zero again
                            state_nxt = ipd_pkg::ST_IDLE;
                            cnt_nxt = '0; // [R11]
                        end else if (ms_tick) begin
                            if (cnt_inc >= inpos_hold_delay_time_r) begin
                                state_nxt = ipd_pkg::ST_EVALUATING; // [R08]
                            end else begin
                                cnt_nxt = cnt_inc;
                            end
                        end
                    end
                    ipd_pkg::ST_EVALUATING: begin
                        prim_nxt = !cmd_present_filt && within1; // [R09]
                        if (cmd_present_filt) begin
                            state_nxt = ipd_pkg::ST_IDLE;
                        end
                    end
                    default: begin
                        state_nxt = ipd_pkg::ST_IDLE;
                    end
                endcase
            end
            default: begin
                state_nxt = ipd_pkg::ST_IDLE;
            end
        endcase
        // a new condition setting always restarts from idle
        if (ctrl_wr) begin
            state_nxt = ipd_pkg::ST_IDLE;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ipd_pkg::ST_IDLE;
            cnt_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // both flags come straight from flops, so they change only on a clock edge
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            inpos_flag_primary <= 1'b0;
            inpos_flag_secondary <= 1'b0;
        end else if (ce) begin
            inpos_flag_primary <= prim_nxt;
            inpos_flag_secondary <= sec_nxt; // [R13]
        end
    end

    // flag edges as interrupt events
    always_comb begin
        evt = '0;
        evt[ipd_pkg::EVT_PRIM_ON] = prim_nxt && !inpos_flag_primary;
        evt[ipd_pkg::EVT_PRIM_OFF] = !prim_nxt && inpos_flag_primary;
        evt[ipd_pkg::EVT_SEC_ON] = sec_nxt && !inpos_flag_secondary;
        evt[ipd_pkg::EVT_SEC_OFF] = !sec_nxt && inpos_flag_secondary;
    end

    assign stat_clr = (wr_commit && paddr == ipd_pkg::OFS_INT_STAT) ? pwdata[EW-1:0] : '0;

    // a set in the clearing cycle wins, so no flag edge is lost
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_stat_r <= '0;
        end else if (ce) begin
            int_stat_r <= (int_stat_r & ~stat_clr) | evt;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(int_stat_r & int_mask_r);
        end
    end

    // one wait state: pready is a flop, so every access takes two edges
    assign apb_access = psel && penable && !pready;
    assign apb_commit = psel && penable && pready;
    assign wr_commit = apb_commit && pwrite && addr_ok && value_ok;
    assign ctrl_wr = wr_commit && paddr == ipd_pkg::OFS_CTRL;

    always_comb begin
        status_word = '0;
        status_word[ipd_pkg::ST_PRIM] = inpos_flag_primary;
        status_word[ipd_pkg::ST_SEC] = inpos_flag_secondary;
        status_word[ipd_pkg::ST_BELOW1] = below1;
        status_word[ipd_pkg::ST_CMD] = cmd_present_filt;
        status_word[ipd_pkg::ST_STATE_LSB +: 2] = state_r;
    end

    // unmapped offsets and out-of-range values answer with an error and change nothing
    always_comb begin
        rd_mux = '0;
        addr_ok = 1'b1;
        value_ok = 1'b1;
        if (paddr == ipd_pkg::OFS_CTRL) begin
            rd_mux = {{(32-ipd_pkg::MODE_W){1'b0}}, inpos_condition_select_r};
            value_ok = pwdata <= 32'(ipd_pkg::MODE_MAX); // [R16]
        end else if (paddr == ipd_pkg::OFS_STATUS) begin
            rd_mux = status_word;
            value_ok = 1'b0;
        end else if (paddr == ipd_pkg::OFS_RANGE1) begin
            rd_mux = {{(32-RW){1'b0}}, inpos_range_primary_r};
            value_ok = pwdata <= 32'(ipd_pkg::RANGE_MAX); // [R18]
        end else if (paddr == ipd_pkg::OFS_RANGE2) begin
            rd_mux = {{(32-RW){1'b0}}, inpos_range_secondary_r};
            value_ok = pwdata <= 32'(ipd_pkg::RANGE_MAX); // [R13]
        end else if (paddr == ipd_pkg::OFS_HOLD) begin
            rd_mux = {{(32-TW){1'b0}}, inpos_hold_delay_time_r};
            value_ok = pwdata <= 32'(ipd_pkg::TIME_MAX); // [R16]
        end else if (paddr == ipd_pkg::OFS_INT_STAT) begin
            rd_mux = {{(32-EW){1'b0}}, int_stat_r};
        end else if (paddr == ipd_pkg::OFS_INT_MASK) begin
            rd_mux = {{(32-EW){1'b0}}, int_mask_r};
        end else begin
            addr_ok = 1'b0;
        end
    end

    // error and read data settle together with pready and stand with it
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (ce) begin
            pready <= apb_access;
            if (apb_access) begin
                pslverr <= !addr_ok || (pwrite && !value_ok);
                prdata <= pwrite ? 32'h00000000 : rd_mux;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // configuration takes a write only at the completing access edge
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            inpos_condition_select_r <= ipd_pkg::RST_MODE;
            inpos_range_primary_r <= ipd_pkg::RST_RANGE1;
            inpos_range_secondary_r <= ipd_pkg::RST_RANGE2;
            inpos_hold_delay_time_r <= ipd_pkg::RST_HOLD;
            int_mask_r <= ipd_pkg::RST_MASK;
        end else if (ce && wr_commit) begin
            if (paddr == ipd_pkg::OFS_CTRL) begin
                inpos_condition_select_r <= pwdata[ipd_pkg::MODE_W-1:0]; // [R16]
            end else if (paddr == ipd_pkg::OFS_RANGE1) begin
                inpos_range_primary_r <= pwdata[RW-1:0]; // [R18]
            end else if (paddr == ipd_pkg::OFS_RANGE2) begin
                inpos_range_secondary_r <= pwdata[RW-1:0]; // [R13]
            end else if (paddr == ipd_pkg::OFS_HOLD) begin
                inpos_hold_delay_time_r <= pwdata[TW-1:0]; // [R16]
            end else if (paddr == ipd_pkg::OFS_INT_MASK) begin
                int_mask_r <= pwdata[EW-1:0];
            end
        end
    end
endmodule : ipd_in_position_detector

// [ipd_loop_model.sv]
// loop stand-in: deviation, filtered command, zero-speed.
// assumes targets change after rising edges.
module ipd_loop_model(input wire logic core_clk, input wire logic signed [27:0] dev_set, input wire logic cmd_set,
    output logic signed [27:0] pos_deviation, output logic cmd_present_filt, output logic zero_speed);
    always_ff @(posedge core_clk) begin
        pos_deviation <= dev_set;
        cmd_present_filt <= cmd_set;
        zero_speed <= (dev_set == pos_deviation); // still deviation reads as stopped
    end
endmodule : ipd_loop_model

// [ipd_in_position_detector_props.sv]
// flag and bus checks on the detector ports.
// assumes ranges stay at reset value; mode in ctrl[2:0].
module ipd_in_position_detector_props(input wire logic core_clk, sys_rst, ce, cmd_present_filt, zero_speed,
    psel, penable, pwrite, pready, pslverr, inpos_flag_primary, inpos_flag_secondary, irq,
    input wire logic signed [27:0] pos_deviation, input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata, prdata);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [2:0] md_r;
    logic [27:0] mag;
    assign mag = pos_deviation[27] ? -pos_deviation : pos_deviation;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) md_r <= 3'h0;
        else if (psel && penable && pready && pwrite && paddr == ipd_pkg::OFS_CTRL
            && pwdata <= 32'h00000004) md_r <= pwdata[2:0];
    end
    AST_SEC_ON: assert property ((mag < 28'h000000A)[*3] |-> inpos_flag_secondary) else $error("sec on");
    AST_SEC_OFF: assert property ((mag >= 28'h000000A)[*3] |-> !inpos_flag_secondary) else $error("sec off");
    AST_M0: assert property ((md_r == 0 && mag < 28'h000000A)[*3] |-> inpos_flag_primary) else $error("m0");
    AST_M1: assert property ((md_r == 1 && cmd_present_filt)[*3] |-> !inpos_flag_primary) else $error("m1");
    AST_M2: assert property ((md_r == 2 && !zero_speed)[*3] |-> !inpos_flag_primary) else $error("m2");
    AST_M3: assert property ((md_r == 3 && cmd_present_filt)[*3] |-> !inpos_flag_primary) else $error("m3");
    AST_M4: assert property ((md_r == 4 && cmd_present_filt)[*3] |-> !inpos_flag_primary) else $error("m4");
    AST_RDY: assert property (psel && penable |-> ##[0:4] pready) else $error("no ready");
    cover property (md_r == 3 && inpos_flag_primary);
    cover property (md_r == 4 && inpos_flag_primary);
    cover property (irq);
endmodule : ipd_in_position_detector_props

// [tb.sv]
// detector bench: apb tasks, scripted loop targets.
// assumes a 4-cycle tick, so 1 ms is 4 clocks.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, cmd_set = 1, ce = 1, cm, zs, pready, f1, f2, irq;
    logic perr, er;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic signed [27:0] dev_set = 0, dev;
    int errors = 0, samples_checked = 0, cyc = 0;
    always #10 core_clk = ~core_clk;
    ipd_loop_model lm_u(.core_clk, .dev_set, .cmd_set, .pos_deviation(dev), .cmd_present_filt(cm), .zero_speed(zs));
    ipd_in_position_detector #(.TICK_CYCLES(4)) dut_u(.core_clk, .sys_rst, .ce, .pos_deviation(dev),
        .cmd_present_filt(cm), .zero_speed(zs), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr(perr), .inpos_flag_primary(f1), .inpos_flag_secondary(f2), .irq);
    task automatic finish_test;
        $display("errors=%0d checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask : cmp
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge core_clk) penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = perr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic st(input logic signed [27:0] d, input logic c, input int n);
        @(posedge core_clk) {dev_set, cmd_set} <= {d, c};
        repeat (n) @(negedge core_clk);
    endtask : st
    always @(posedge core_clk) if (++cyc == 3000) begin errors++; finish_test; end
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        apb(0, ipd_pkg::OFS_RANGE1, 0); cmp("range1", 32'h0000000A, rd);
        apb(1, ipd_pkg::OFS_INT_MASK, 32'h0000000F);
        apb(1, ipd_pkg::OFS_CTRL, 0); st(-5, 1, 4); cmp("m0", 1, f1);
        cmp("sec", 1, f2);
        cmp("irq", 1, irq);
        apb(1, ipd_pkg::OFS_INT_STAT, 32'h0000000F); st(-5, 1, 2); cmp("irq clr", 0, irq);
        apb(1, ipd_pkg::OFS_CTRL, 1); st(-5, 1, 4); cmp("m1", 0, f1);
        st(20, 0, 4); cmp("sec off", 0, f2);
        apb(1, ipd_pkg::OFS_CTRL, 2); st(5, 0, 4); cmp("m2", 1, f1);
        apb(1, ipd_pkg::OFS_HOLD, 3); apb(1, ipd_pkg::OFS_CTRL, 3); st(20, 0, 4);
        st(5, 0, 4); st(100, 0, 4); cmp("hold", 1, f1);
        st(100, 0, 20); cmp("expired", 0, f1);
        apb(1, ipd_pkg::OFS_CTRL, 4); st(5, 1, 4); st(5, 0, 4); cmp("delay", 0, f1);
        st(5, 0, 16); cmp("eval", 1, f1);
        apb(1, ipd_pkg::OFS_CTRL, 5); cmp("slverr", 1, er);
        apb(0, ipd_pkg::OFS_CTRL, 0); cmp("mode kept", 4, rd);
        finish_test;
    end
endmodule : tb
bind ipd_in_position_detector ipd_in_position_detector_props pr_u(.*);
